/* File: power_wake_reset_control_consts.svh */
// Offsets, reset values, field positions and timing for the wake and reset control
`ifndef POWER_WAKE_RESET_CONTROL_CONSTS_SVH
`define POWER_WAKE_RESET_CONTROL_CONSTS_SVH
`define OFF_PSEQ        8'hE6
`define OFF_WAKE        8'hE7
`define OFF_RSTEN       8'hF2
`define RST_PSEQ        8'h1C
`define RST_WAKE        8'h00
`define RST_RSTEN       8'h7C
`define B_MOUSE         7
`define B_CHASSIS       5
`define B_LAST_OFF      4
`define B_S1_FAST       3
`define B_S2_HI         2
`define B_S2_LO         1
`define B_TRIG          0
`define B_KSET3         7
`define B_KSET2         6
`define B_DEDKEY        5
`define B_PULSE         4
`define B_WDT_SRC       3
`define B_HM_SRC        0
`define B_RST_HI        6
`define B_RST_LO        2
`define B_PME           0
`define POL_OFF         2'h0
`define POL_ON          2'h1
`define POL_PRIOR       2'h2
`define POL_USER        2'h3
`define CLK_KHZ         25000
`define T_S1_SLOW_MS    300
`define T_S1_FAST_MS    200
`define T_S2_1_MS       32
`define T_S2_2_MS       96
`define T_S2_3_MS       250
`define T_PULSE_MS      500
`define CNT_W           24
`endif

/* File: power_wake_reset_control_pkg.sv */
// Types for the wake and reset control block
`default_nettype none
package power_wake_reset_control_pkg;
    typedef enum logic [1:0] {
        PG_OFF    = 2'h0,
        PG_STAGE1 = 2'h1,
        PG_STAGE2 = 2'h2,
        PG_ON     = 2'h3
    } pg_state_t;
    typedef struct packed {
        logic        mouse_combo;
        logic        chassis_clr;
        logic        last_off;
        logic        s1_fast;
        logic [1:0]  s2_sel;
        logic        kset3;
        logic        kset2;
        logic        ded_en;
        logic        pulse_en;
        logic        wdt_src;
        logic        hm_src;
        logic [4:0]  rst_en;
        logic        pme_en;
        pg_state_t   pg;
        logic [23:0] cnt;
        logic [23:0] pcnt;
        logic        key_q;
        logic        fspg;
        logic        spg;
        logic        power_button_out_n_n;
        logic        wdt_rst_n;
        logic        hm_rst_n;
        logic [4:0]  rst_out_n;
        logic        pme_out_n;
        logic [7:0]  rdata;
    } state_t;
endpackage : power_wake_reset_control_pkg
`default_nettype wire

/* File: power_wake_reset_control.sv */
// Power-good sequencing, wake enables and reset routing
`timescale 1ns/10ps
`default_nettype none
`include "power_wake_reset_control_consts.svh"
module power_wake_reset_control #(
    parameter int S1_SLOW_CYC = `T_S1_SLOW_MS * `CLK_KHZ,
    parameter int S1_FAST_CYC = `T_S1_FAST_MS * `CLK_KHZ,
    parameter int S2_1_CYC    = `T_S2_1_MS * `CLK_KHZ,
    parameter int S2_2_CYC    = `T_S2_2_MS * `CLK_KHZ,
    parameter int S2_3_CYC    = `T_S2_3_MS * `CLK_KHZ,
    parameter int PULSE_CYC   = `T_PULSE_MS * `CLK_KHZ
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       bat_rst_b,
    input  wire logic       host_reset_n,
    input  wire logic       cfg_rd,
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata_r,
    input  wire logic       standby_power_good,
    input  wire logic [1:0] power_loss_policy,
    input  wire logic       prior_state_off,
    input  wire logic       power_return,
    input  wire logic       kbd_wake_enable,
    input  wire logic       dedicated_key,
    input  wire logic       wake_event_req,
    output logic            first_stage_power_good_r,
    output logic            system_power_good_r,
    output logic            power_button_out_n_r,
    output logic            mouse_wake_combo_select_r,
    output logic            chassis_intrusion_clear_r,
    output logic            third_key_set_enable_r,
    output logic            second_key_set_enable_r,
    output logic            watchdog_reset_n_r,
    output logic            monitor_reset_n_r,
    output logic      [4:0] reset_out_n_r,
    output logic            wake_event_out_n_r
);
    power_wake_reset_control_pkg::state_t s_r;
    power_wake_reset_control_pkg::state_t s_nxt;
    logic [`CNT_W-1:0] d1;
    logic [`CNT_W-1:0] d2;
    logic              trig;
    logic              restore_on;
    logic              key_wake;
    logic              pulse_go;

    always_comb begin
        d1 = s_r.s1_fast ? S1_FAST_CYC[`CNT_W-1:0] : S1_SLOW_CYC[`CNT_W-1:0];
        case (s_r.s2_sel)
            2'h1:    d2 = S2_1_CYC[`CNT_W-1:0];
            2'h2:    d2 = S2_2_CYC[`CNT_W-1:0];
            2'h3:    d2 = S2_3_CYC[`CNT_W-1:0];
            default: d2 = '0;
        endcase
        trig = cfg_wr && cfg_addr == `OFF_PSEQ && cfg_wdata[`B_TRIG];
        case (power_loss_policy)
            `POL_ON:    restore_on = 1'b1;
            `POL_PRIOR: restore_on = !prior_state_off;
            `POL_USER:  restore_on = !s_r.last_off;
            default:    restore_on = 1'b0;
        endcase
        key_wake = dedicated_key && !s_r.key_q && s_r.ded_en && kbd_wake_enable;
        pulse_go = (power_return && s_r.pulse_en && restore_on) || key_wake;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.key_q = dedicated_key;
        // Register reads, reserved bits as zero
        if (cfg_rd) begin
            case (cfg_addr)
                `OFF_PSEQ: s_nxt.rdata = {s_r.mouse_combo, 1'b0, s_r.chassis_clr,
                                          s_r.last_off, s_r.s1_fast, s_r.s2_sel, 1'b0};
                `OFF_WAKE: s_nxt.rdata = {s_r.kset3, s_r.kset2, s_r.ded_en, s_r.pulse_en,
                                          s_r.wdt_src, 2'h0, s_r.hm_src};
                `OFF_RSTEN: s_nxt.rdata = {1'b0, s_r.rst_en, 1'b0, s_r.pme_en};
                default:   s_nxt.rdata = 8'h00;
            endcase
        end
        // Register writes
        if (cfg_wr) begin
            case (cfg_addr)
                `OFF_PSEQ: begin
                    s_nxt.mouse_combo = cfg_wdata[`B_MOUSE];
                    s_nxt.chassis_clr = cfg_wdata[`B_CHASSIS];
                    s_nxt.last_off    = cfg_wdata[`B_LAST_OFF];
                    s_nxt.s1_fast     = cfg_wdata[`B_S1_FAST];
                    s_nxt.s2_sel      = cfg_wdata[`B_S2_HI:`B_S2_LO];
                end
                `OFF_WAKE: begin
                    s_nxt.kset3    = cfg_wdata[`B_KSET3];
                    s_nxt.kset2    = cfg_wdata[`B_KSET2];
                    s_nxt.ded_en   = cfg_wdata[`B_DEDKEY];
                    s_nxt.pulse_en = cfg_wdata[`B_PULSE];
                    s_nxt.wdt_src  = cfg_wdata[`B_WDT_SRC];
                    s_nxt.hm_src   = cfg_wdata[`B_HM_SRC];
                end
                `OFF_RSTEN: begin
                    s_nxt.rst_en = cfg_wdata[`B_RST_HI:`B_RST_LO];
                    s_nxt.pme_en = cfg_wdata[`B_PME];
                end
                default: ;
            endcase
        end
        // Power-good delay chain
        case (s_r.pg)
            power_wake_reset_control_pkg::PG_OFF: begin
                s_nxt.fspg = 1'b0;
                s_nxt.spg  = 1'b0;
                s_nxt.cnt  = '0;
                s_nxt.pg   = power_wake_reset_control_pkg::PG_STAGE1;
            end
            power_wake_reset_control_pkg::PG_STAGE1: begin
                if (s_r.cnt >= d1) begin
                    s_nxt.fspg = 1'b1;
                    s_nxt.cnt  = '0;
                    s_nxt.pg   = power_wake_reset_control_pkg::PG_STAGE2;
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end
            power_wake_reset_control_pkg::PG_STAGE2: begin
                if (s_r.cnt >= d2) begin
                    s_nxt.spg = 1'b1;
                    s_nxt.pg  = power_wake_reset_control_pkg::PG_ON;
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end
            power_wake_reset_control_pkg::PG_ON: begin
                if (trig) begin
                    s_nxt.spg = 1'b0;
                    s_nxt.cnt = '0;
                    s_nxt.pg  = power_wake_reset_control_pkg::PG_STAGE2;
                end
            end
            default: s_nxt.pg = power_wake_reset_control_pkg::PG_OFF;
        endcase
        if (!standby_power_good) begin
            s_nxt.fspg = 1'b0;
            s_nxt.spg  = 1'b0;
            s_nxt.cnt  = '0;
            s_nxt.pg   = power_wake_reset_control_pkg::PG_OFF;
        end
        // Power button pulse
        if (pulse_go) begin
            s_nxt.pcnt = PULSE_CYC[`CNT_W-1:0];
        end else if (s_r.pcnt != '0) begin
            s_nxt.pcnt = s_r.pcnt - 1'b1;
        end
        // Battery domain reset
        if (!bat_rst_b) begin
            s_nxt.last_off = 1'(`RST_PSEQ >> `B_LAST_OFF);
            s_nxt.pulse_en = 1'(`RST_WAKE >> `B_PULSE);
            s_nxt.hm_src   = 1'(`RST_WAKE >> `B_HM_SRC);
        end
        // Standby domain reset, battery bits kept
        if (!rst_b) begin
            s_nxt.mouse_combo = 1'(`RST_PSEQ >> `B_MOUSE);
            s_nxt.chassis_clr = 1'(`RST_PSEQ >> `B_CHASSIS);
            s_nxt.s1_fast     = 1'(`RST_PSEQ >> `B_S1_FAST);
            s_nxt.s2_sel      = 2'(`RST_PSEQ >> `B_S2_LO);
            s_nxt.kset3       = 1'(`RST_WAKE >> `B_KSET3);
            s_nxt.kset2       = 1'(`RST_WAKE >> `B_KSET2);
            s_nxt.ded_en      = 1'(`RST_WAKE >> `B_DEDKEY);
            s_nxt.wdt_src     = 1'(`RST_WAKE >> `B_WDT_SRC);
            s_nxt.rst_en      = 5'(`RST_RSTEN >> `B_RST_LO);
            s_nxt.pme_en      = 1'(`RST_RSTEN >> `B_PME);
            s_nxt.pg          = power_wake_reset_control_pkg::PG_OFF;
            s_nxt.cnt         = '0;
            s_nxt.pcnt        = '0;
            s_nxt.key_q       = 1'b0;
            s_nxt.fspg        = 1'b0;
            s_nxt.spg         = 1'b0;
            s_nxt.rdata       = 8'h00;
        end
        // Output stage
        s_nxt.power_button_out_n_n   = s_nxt.pcnt == '0;
        s_nxt.wdt_rst_n = s_nxt.wdt_src ? s_nxt.spg : host_reset_n;
        s_nxt.hm_rst_n  = s_nxt.hm_src ? host_reset_n : s_nxt.spg;
        for (int i = 0; i < 5; i++) begin
            s_nxt.rst_out_n[i] = !s_nxt.rst_en[i] || host_reset_n;
        end
        s_nxt.pme_out_n = !(s_nxt.pme_en && wake_event_req);
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign cfg_rdata_r               = s_r.rdata;
    assign first_stage_power_good_r  = s_r.fspg;
    assign system_power_good_r       = s_r.spg;
    assign power_button_out_n_r      = s_r.power_button_out_n_n;
    assign mouse_wake_combo_select_r = s_r.mouse_combo;
    assign chassis_intrusion_clear_r = s_r.chassis_clr;
    assign third_key_set_enable_r    = s_r.kset3;
    assign second_key_set_enable_r   = s_r.kset2;
    assign watchdog_reset_n_r        = s_r.wdt_rst_n;
    assign monitor_reset_n_r         = s_r.hm_rst_n;
    assign reset_out_n_r             = s_r.rst_out_n;
    assign wake_event_out_n_r        = s_r.pme_out_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence retrig_s;
        s_r.pg == power_wake_reset_control_pkg::PG_ON && trig && standby_power_good;
    endsequence
    sequence wr_pseq_s;
        cfg_wr && cfg_addr == `OFF_PSEQ && bat_rst_b;
    endsequence

    retrig_drop_a: assert property (retrig_s |=> !system_power_good_r)
        else $error("power good did not drop on retrigger");
    retrig_rise_a: assert property (retrig_s ##1 (s_r.s2_sel == 2'h0 && standby_power_good)
                                   |=> system_power_good_r)
        else $error("power good did not rise after zero delay");
    stage_order_a: assert property (system_power_good_r |-> first_stage_power_good_r)
        else $error("second stage up before first");
    stage1_wait_a: assert property ($rose(first_stage_power_good_r)
                                   |-> $past(s_r.cnt) >= $past(d1))
        else $error("first stage rose early");
    last_state_a: assert property (wr_pseq_s |=> s_r.last_off == $past(cfg_wdata[`B_LAST_OFF]))
        else $error("last state flag not stored");
    pulse_start_a: assert property (pulse_go |=> !power_button_out_n_r [*8])
        else $error("power button pulse missing");
    wdt_src_a: assert property (s_r.wdt_src |-> watchdog_reset_n_r == system_power_good_r)
        else $error("watchdog reset source wrong");
    hm_src_a: assert property (!s_r.hm_src |-> monitor_reset_n_r == system_power_good_r)
        else $error("monitor reset source wrong");
    pme_gate_a: assert property (!s_r.pme_en |-> wake_event_out_n_r)
        else $error("wake event passed while disabled");
    reserved_rd_a: assert property (cfg_rd && cfg_addr == `OFF_WAKE
                                   |=> cfg_rdata_r[2:1] == 2'h0)
        else $error("reserved bits read nonzero");
    key_set_a: assert property (cfg_wr && cfg_addr == `OFF_WAKE
                               |=> third_key_set_enable_r == $past(cfg_wdata[`B_KSET3]))
        else $error("third key set enable not stored");

    sequence pulse_req_s;
        power_return && s_r.pulse_en;
    endsequence
    sequence user_on_s;
        power_loss_policy == `POL_USER && !s_r.last_off;
    endsequence

    mouse_sel_a: assert property (cfg_wr && cfg_addr == `OFF_PSEQ
        |=> mouse_wake_combo_select_r == $past(cfg_wdata[`B_MOUSE]))
        else $error("mouse combination select not stored");
    chassis_clr_a: assert property (cfg_wr && cfg_addr == `OFF_PSEQ
        |=> chassis_intrusion_clear_r == $past(cfg_wdata[`B_CHASSIS]))
        else $error("chassis clear bit not stored");
    key_set2_a: assert property (cfg_wr && cfg_addr == `OFF_WAKE
        |=> second_key_set_enable_r == $past(cfg_wdata[`B_KSET2]))
        else $error("second key set enable not stored");
    stage2_wait_a: assert property ($rose(system_power_good_r)
        |-> $past(s_r.cnt) >= $past(d2))
        else $error("second stage rose early");
    standby_drop_a: assert property (!standby_power_good
        |=> !first_stage_power_good_r && !system_power_good_r)
        else $error("power good held without standby");
    retrig_bit_a: assert property (cfg_rd && cfg_addr == `OFF_PSEQ
        |=> !cfg_rdata_r[`B_TRIG])
        else $error("retrigger bit reads set");
    key_wake_a: assert property (key_wake |=> !power_button_out_n_r)
        else $error("dedicated key did not wake");
    user_policy_a: assert property (pulse_req_s ##0 user_on_s
        |=> !power_button_out_n_r)
        else $error("software last state not restored");
    pme_pass_a: assert property (s_r.pme_en && wake_event_req && !cfg_wr
        |=> !wake_event_out_n_r)
        else $error("wake event blocked while enabled");
    hm_host_a: assert property (s_r.hm_src && bat_rst_b && !cfg_wr
        |=> monitor_reset_n_r == $past(host_reset_n))
        else $error("monitor reset not from host reset");
    wdt_host_a: assert property (!s_r.wdt_src && !cfg_wr
        |=> watchdog_reset_n_r == $past(host_reset_n))
        else $error("watchdog reset not from host reset");
endmodule : power_wake_reset_control
`default_nettype wire

/* File: power_supply_model.sv */
// Host chipset and supply model driving power and reset levels
`timescale 1ns/10ps
`default_nettype none
module power_supply_model (
    input  wire logic clk,
    input  wire logic sb_req,
    input  wire logic hr_req,
    input  wire logic ret_req,
    output logic      standby_power_good,
    output logic      host_reset_n,
    output logic      power_return
);
    initial {standby_power_good, host_reset_n, power_return} = 3'h2;
    // Levels follow requests one edge later
    always @(posedge clk) begin
        standby_power_good <= #1 sb_req;
        host_reset_n       <= #1 hr_req;
        power_return       <= #1 ret_req;
    end
endmodule : power_supply_model
`default_nettype wire

/* File: power_wake_reset_control_tb.sv */
// Self-checking bench for the wake and reset control block
`timescale 1ns/10ps
`default_nettype none
module power_wake_reset_control_tb;
    localparam int S1 [2] = '{20, 10};
    localparam int S2 [4] = '{0, 4, 8, 12};
    localparam int PUL    = 16;
    logic        clk = 1'b0, rst_b = 1'b0, bat_rst_b = 1'b0;
    logic        rd = 1'b0, wr = 1'b0, rd_d = 1'b0, ex;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, e7, f2;
    logic [1:0]  pol = 2'h0;
    logic        prior_off = 1'b0, kbd_en = 1'b0, ded_key = 1'b0, wake_req = 1'b0;
    logic        sb_req = 1'b0, hr_req = 1'b1, ret_req = 1'b0;
    logic [31:0] lf = 32'h9A4127E8;
    logic [7:0]  exp_q [$];
    wire logic   sb, hrn, pret, fspg, spg, power_button_out_n_n, mouse, chas, k3, k2, wdt_n, mon_n, pme_n;
    wire logic [7:0] rdata;
    wire logic [4:0] rout_n;
    int          err_count = 0, n_checks = 0, c;

    power_supply_model power_supply_model_i (.clk(clk), .sb_req(sb_req), .hr_req(hr_req),
        .ret_req(ret_req), .standby_power_good(sb), .host_reset_n(hrn), .power_return(pret));
    power_wake_reset_control #(.S1_SLOW_CYC(S1[0]), .S1_FAST_CYC(S1[1]), .S2_1_CYC(S2[1]),
        .S2_2_CYC(S2[2]), .S2_3_CYC(S2[3]), .PULSE_CYC(PUL)) power_wake_reset_control_i (
        .clk(clk), .rst_b(rst_b), .bat_rst_b(bat_rst_b), .host_reset_n(hrn), .cfg_rd(rd),
        .cfg_wr(wr), .cfg_addr(addr), .cfg_wdata(wdata), .cfg_rdata_r(rdata),
        .standby_power_good(sb), .power_loss_policy(pol), .prior_state_off(prior_off),
        .power_return(pret), .kbd_wake_enable(kbd_en), .dedicated_key(ded_key),
        .wake_event_req(wake_req), .first_stage_power_good_r(fspg),
        .system_power_good_r(spg), .power_button_out_n_r(power_button_out_n_n),
        .mouse_wake_combo_select_r(mouse), .chassis_intrusion_clear_r(chas),
        .third_key_set_enable_r(k3), .second_key_set_enable_r(k2),
        .watchdog_reset_n_r(wdt_n), .monitor_reset_n_r(mon_n), .reset_out_n_r(rout_n),
        .wake_event_out_n_r(pme_n));

    always #20 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int k = 1);
        repeat (k) @(posedge clk);
        #2;
    endtask : cyc

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        cyc();
        wr = 1'b0;
        cyc();
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        rd = 1'b1;
        addr = a;
        exp_q.push_back(e);
        cyc();
        rd = 1'b0;
        cyc();
    endtask : rreg

    // Edges until the chosen output is high, bounded
    task automatic cnt(input int s, output int n);
        n = 0;
        do begin
            cyc();
            n++;
        end while ((s == 0 ? fspg : s == 1 ? spg : power_button_out_n_n) !== 1'b1 && n < 300);
        if (n >= 300) begin
            err_count++;
            conclude();
        end
    endtask : cnt

    // Read results compared against the oldest note
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d) chk(rdata, exp_q.pop_front(), "read");

    initial begin
        cyc(2);
        rst_b = 1'b1;
        bat_rst_b = 1'b1;
        rreg(8'hE6, 8'h1C);
        rreg(8'hE7, 8'h00);
        rreg(8'hF2, 8'h7C);
        wreg(8'hE8, 8'hFF);
        rreg(8'hE8, 8'h00);
        for (int i = 0; i < 6; i++) begin
            lf = lfsr(lf);
            wreg(8'hE6, lf[7:0]);
            wreg(8'hE7, lf[15:8]);
            wreg(8'hF2, lf[23:16]);
            rreg(8'hE6, lf[7:0] & 8'hBE);
            rreg(8'hE7, lf[15:8] & 8'hF9);
            rreg(8'hF2, lf[23:16] & 8'h7D);
            chk(mouse, lf[7], "mouse");
            chk(chas, lf[5], "chassis");
            chk(k3, lf[15], "kset3");
            chk(k2, lf[14], "kset2");
        end
        $display("test registers done");
        for (int s = 0; s < 8; s++) begin
            sb_req = 1'b0;
            wreg(8'hE6, {4'h0, s[2], s[1:0], 1'b0});
            chk(spg, 1'b0, "drop");
            chk(chas, 1'b0, "chassis off");
            sb_req = 1'b1;
            cyc();
            cnt(0, c);
            chk(8'(c), 8'(S1[s[2]] + 2), "stage one");
            cnt(1, c);
            chk(8'(c), 8'(S2[s[1:0]] + 1), "stage two");
        end
        wreg(8'hE6, 8'h05);
        chk(spg, 1'b0, "retrigger low");
        cnt(1, c);
        chk(8'(c), 8'(S2[2]), "retrigger");
        rreg(8'hE6, 8'h04);
        wreg(8'hE6, 8'h01);
        chk(spg, 1'b1, "retrigger zero delay");
        $display("test power good done");
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            hr_req = lf[0];
            wake_req = lf[1];
            e7 = lf[15:8] & 8'h09;
            f2 = lf[23:16];
            wreg(8'hE7, e7);
            wreg(8'hF2, f2);
            chk(wdt_n, e7[3] ? 1'b1 : hrn, "watchdog");
            chk(mon_n, e7[0] ? hrn : 1'b1, "monitor");
            chk(rout_n, 5'(~(f2[6:2] & ~{5{hrn}})), "reset outs");
            chk(pme_n, !(f2[0] && wake_req), "event out");
        end
        $display("test routing done");
        for (int p = 0; p < 8; p++) begin
            pol = p[1:0];
            prior_off = p[2];
            ex = p[1:0] == 2'h1 || (p[1:0] == 2'h2 && !p[2]) || (p[1:0] == 2'h3 && p[2]);
            wreg(8'hE6, {3'h0, !p[2], 4'h0});
            wreg(8'hE7, 8'h10);
            ret_req = 1'b1;
            cyc();
            ret_req = 1'b0;
            cyc();
            chk(power_button_out_n_n, !ex, "pulse start");
            if (ex) begin
                cnt(2, c);
                chk(8'(c), 8'(PUL), "pulse length");
            end
        end
        wreg(8'hE7, 8'h20);
        for (int k = 0; k < 2; k++) begin
            kbd_en = k[0];
            ded_key = 1'b1;
            cyc();
            ded_key = 1'b0;
            cyc();
            chk(power_button_out_n_n, !k[0], "key wake");
            if (k[0]) begin
                cnt(2, c);
                chk(8'(c), 8'(PUL - 1), "key pulse");
            end
        end
        $display("test power button done");
        wreg(8'hE7, 8'h31);
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        rreg(8'hE6, 8'h0C);
        rreg(8'hE7, 8'h11);
        rreg(8'hF2, 8'h7C);
        $display("test reset done");
        conclude();
    end
endmodule : power_wake_reset_control_tb
`default_nettype wire
